// [design/eeprom_pkg.sv]
// shared constants for the two-wire eeprom command engine
package eeprom_pkg;
  localparam int ADDR_W = 11;
  localparam int WORD_W = 8;
  localparam int PAGE_W = 4;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned WRITE_TIME_US = 6000;
  localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * (CLK_HZ / 1000000));
endpackage

// [design/two_wire_eeprom_rw_engine.sv]
// two-wire serial eeprom slave engine: byte/page write, polling, protect, reads
// What this block does
// - write sends eight-bit word address after slave
// - acknowledge word address and each data byte
// - stop ends write and starts programming
// - ignore bus while programming runs
// - pages are 16 bytes on 16-byte boundaries
// - page write address wraps inside page
// - page write may start mid page
// - up to 15 further bytes, each acked, counter advances
// - over sixteen bytes overwrite earlier ones
// - busy poll gets no ack until done
// - protected upper half: no data ack, no program
// - read direction bit set to one
// - counter holds last address plus one
// - current read sends byte, stops on nack
// - master ack requests next sequential byte
// - read increment wraps whole array
// - respond only to device type 1010
// - three block bits pick one of eight blocks
// - release line after byte, sample ack
`timescale 1ns/1ps
`default_nettype none
module two_wire_eeprom_rw_engine #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter int DEPTH = 2048
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic master_ack_valid,
  input wire logic master_ack,
  input wire logic write_guard,
  output logic slave_ack,
  output logic ack_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic prog_busy,
  output logic prog_start,
  output logic [10:0] prog_addr
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {IDLE, WORD, DATA, RD, NACKED, BLOCKED} st_t;
  localparam logic [31:0] WCNT = 32'(WRITE_CYCLES);

  // page wrap keeps upper bits, advances only the low four
  function automatic logic [10:0] page_inc(input logic [10:0] a);
    page_inc = {a[10:eeprom_pkg::PAGE_W], a[eeprom_pkg::PAGE_W-1:0] + 4'h1};
  endfunction

  logic [7:0] mem [DEPTH];
  logic [7:0] pbuf_q [16];
  logic [15:0] pmask_q, pmask_d;
  st_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [2:0] blk_q, blk_d;
  logic wr_pend_q, wr_pend_d;
  logic [31:0] busy_q, busy_d;
  logic ack_q, ack_d, ackv_q, ackv_d;
  logic [7:0] txd_q, txd_d;
  logic txv_q, txv_d, ps_q, ps_d;
  logic [10:0] pa_q, pa_d;
  logic [1:0] nbyte_q, nbyte_d;
  logic pbusy_q, pbusy_d;
  logic wg_meta_q, wg_q;
  logic dev_hit, busy;

  // write guard is a board pin: two stages before any logic reads it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wg_meta_q <= 1'b0;
      wg_q <= 1'b0;
    end else begin
      wg_meta_q <= write_guard;
      wg_q <= wg_meta_q;
    end
  end

  assign busy = (busy_q != 32'h0);
  assign dev_hit = (byte_data[7:4] == eeprom_pkg::DEV_TYPE);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    blk_d = blk_q;
    wr_pend_d = wr_pend_q;
    busy_d = busy_q;
    ack_d = 1'b0;
    ackv_d = 1'b0;
    txd_d = txd_q;
    txv_d = 1'b0;
    ps_d = 1'b0;
    pa_d = pa_q;
    pmask_d = pmask_q;
    nbyte_d = nbyte_q;
    if (busy) begin
      busy_d = busy_q - 32'h1;
      if (byte_valid && st_q == IDLE) begin
        ack_d = 1'b0;
        ackv_d = 1'b1;
      end
      if (start_seen || stop_seen) begin
        st_d = IDLE;
      end
    end else if (stop_seen) begin
      st_d = IDLE;
      if (wr_pend_q) begin
        busy_d = WCNT;
        ps_d = 1'b1;
        wr_pend_d = 1'b0;
      end
    end else if (start_seen) begin
      st_d = IDLE;
      nbyte_d = 2'd0;
    end else begin
      case (st_q)
        IDLE: begin
          if (byte_valid && nbyte_q == 2'd0) begin
            nbyte_d = 2'd1;
            if (dev_hit) begin
              blk_d = byte_data[3:1];
              ack_d = 1'b1;
              ackv_d = 1'b1;
              if (byte_data[0]) begin
                st_d = RD;
                txd_d = mem[cnt_q];
                txv_d = 1'b1;
                cnt_d = cnt_q + 11'h1;
              end else begin
                st_d = WORD;
              end
            end else begin
              st_d = BLOCKED;
            end
          end
        end
        WORD: begin
          if (byte_valid) begin
            cnt_d = {blk_q, byte_data};
            ack_d = 1'b1;
            ackv_d = 1'b1;
            pmask_d = 16'h0;
            st_d = DATA;
          end
        end
        DATA: begin
          if (byte_valid) begin
            ackv_d = 1'b1;
            if (wg_q && cnt_q[10]) begin
              ack_d = 1'b0;
              wr_pend_d = 1'b0;
              st_d = BLOCKED;
            end else begin
              ack_d = 1'b1;
              wr_pend_d = 1'b1;
              pa_d = {cnt_q[10:4], 4'h0};
              pmask_d = pmask_q | (16'h1 << cnt_q[3:0]);
              cnt_d = page_inc(cnt_q);
            end
          end
        end
        RD: begin
          if (master_ack_valid) begin
            if (master_ack) begin
              txd_d = mem[cnt_q];
              txv_d = 1'b1;
              cnt_d = cnt_q + 11'h1;
            end else begin
              st_d = NACKED;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // busy flag registered so the output comes straight from a flop
    pbusy_d = (busy_d != 32'h0);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= IDLE;
      cnt_q <= eeprom_pkg::ADDR_RST;
      blk_q <= 3'h0;
      wr_pend_q <= 1'b0;
      busy_q <= 32'h0;
      ack_q <= 1'b0;
      ackv_q <= 1'b0;
      txd_q <= eeprom_pkg::BYTE_RST;
      txv_q <= 1'b0;
      ps_q <= 1'b0;
      pa_q <= eeprom_pkg::ADDR_RST;
      pmask_q <= 16'h0;
      nbyte_q <= 2'd0;
      pbusy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      blk_q <= blk_d;
      wr_pend_q <= wr_pend_d;
      busy_q <= busy_d;
      ack_q <= ack_d;
      ackv_q <= ackv_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
      ps_q <= ps_d;
      pa_q <= pa_d;
      pmask_q <= pmask_d;
      nbyte_q <= nbyte_d;
      pbusy_q <= pbusy_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // staged page buffer, committed to the array at the programming start
  always_ff @(posedge ref_clk) begin
    if (!busy && !stop_seen && !start_seen && st_q == DATA && byte_valid
        && !(wg_q && cnt_q[10])) begin
      pbuf_q[cnt_q[3:0]] <= byte_data;
    end
    if (ps_q) begin
      for (int i = 0; i < 16; i++) begin
        if (pmask_q[i]) begin
          mem[{pa_q[10:4], 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  assign slave_ack = ack_q;
  assign ack_valid = ackv_q;
  assign tx_data = txd_q;
  assign tx_valid = txv_q;
  assign prog_busy = pbusy_q;
  assign prog_start = ps_q;
  assign prog_addr = pa_q;

  //////////////////////////////////////////////////////////////////////////////
  a_busy_no_ack: assert property (@(posedge ref_clk) disable iff (rst)
    busy && byte_valid |=> !slave_ack) else $error("ack while programming");
  a_stop_starts: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && stop_seen && wr_pend_q |=> prog_start && busy) else $error("no program");
  a_guard_nack: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == DATA && byte_valid
    && wg_q && cnt_q[10] |=> ack_valid && !slave_ack && !wr_pend_q)
    else $error("protected byte acked");
  a_page_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == DATA && st_d == DATA && cnt_d != cnt_q |-> cnt_d[10:4] == cnt_q[10:4])
    else $error("page crossed");
  a_read_incr: assert property (@(posedge ref_clk) disable iff (rst)
    tx_valid |-> cnt_q == $past(cnt_q) + 11'h1) else $error("read counter");
  a_word_load: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == WORD && byte_valid
    |=> cnt_q == {blk_q, $past(byte_data)}) else $error("word load");
  a_type_match: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == IDLE && nbyte_q == 2'd0
    && byte_valid && !dev_hit |=> !slave_ack) else $error("foreign ack");
  a_nack_stops: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == NACKED |=> !tx_valid) else $error("sent after nack");
  a_word_ack: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == WORD && byte_valid
    |=> ack_valid && slave_ack) else $error("word address not acked");
  a_data_ack: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == DATA && byte_valid && !(wg_q && cnt_q[10])
    |=> ack_valid && slave_ack && wr_pend_q) else $error("data byte not acked");
  a_page_base: assert property (@(posedge ref_clk) disable iff (rst)
    prog_start |-> prog_addr[3:0] == 4'h0) else $error("page base not aligned");
  a_start_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    prog_start |=> !prog_start) else $error("program start too long");
  a_busy_mute: assert property (@(posedge ref_clk) disable iff (rst)
    busy |=> !tx_valid) else $error("data sent while programming");
  a_read_ack: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == IDLE && nbyte_q == 2'd0
    && byte_valid && dev_hit && byte_data[0] |=> tx_valid && slave_ack) else $error("no read");
  a_blk_load: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == IDLE && nbyte_q == 2'd0
    && byte_valid && dev_hit |=> blk_q == $past(byte_data[3:1])) else $error("block bits");
  a_seq_next: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && !stop_seen && !start_seen && st_q == RD && master_ack_valid && master_ack
    |=> tx_valid) else $error("no next byte after ack");
  a_no_prog: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && stop_seen && !wr_pend_q |=> !prog_start) else $error("program without data");
  a_stop_idle: assert property (@(posedge ref_clk) disable iff (rst)
    stop_seen |=> st_q == IDLE) else $error("stop not honoured");
  a_ack_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    ack_valid |=> !ack_valid) else $error("ack pulse too long");
  a_busy_out: assert property (@(posedge ref_clk) disable iff (rst)
    prog_start |-> prog_busy) else $error("busy not shown at program start");
endmodule
`default_nettype wire

// [sim/two_wire_master_model.sv]
// bus master model driving start, stop, byte and ack pulses
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
  input wire logic ref_clk,
  input wire logic slave_ack,
  input wire logic ack_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic start_seen,
  output logic stop_seen,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic master_ack_valid,
  output logic master_ack
);
  logic got;
  logic [7:0] rx;
  initial begin
    {start_seen, stop_seen, byte_valid, master_ack_valid, master_ack} = '0;
    byte_data = 8'h00;
  end
  task automatic cond(input logic is_stop);
    @(posedge ref_clk) #1;
    if (is_stop) stop_seen = 1'b1;
    else start_seen = 1'b1;
    @(posedge ref_clk) #1;
    {start_seen, stop_seen} = '0;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk) #1;
    byte_valid = 1'b1;
    byte_data = b;
    @(posedge ref_clk) #1;
    byte_valid = 1'b0;
    // released data never keeps the old value
    byte_data = ~b;
    got = ack_valid & slave_ack;
    rx = tx_valid ? tx_data : 8'h00;
  endtask
  task automatic next(input logic a);
    @(posedge ref_clk) #1;
    master_ack_valid = 1'b1;
    master_ack = a;
    @(posedge ref_clk) #1;
    master_ack_valid = 1'b0;
    rx = tx_valid ? tx_data : 8'h00;
  endtask
endmodule
`default_nettype wire

// [sim/test_two_wire_eeprom_rw_engine.sv]
// self-checking bench for the eeprom command engine
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_eeprom_rw_engine;
  localparam int unsigned WC = 20;
  logic ref_clk, rst, write_guard, start_seen, stop_seen, byte_valid;
  logic master_ack_valid, master_ack, slave_ack, ack_valid, tx_valid;
  logic prog_busy, prog_start;
  logic [7:0] byte_data, tx_data;
  logic [10:0] prog_addr;
  int num_errors = 0;
  int tests_run = 0;
  two_wire_eeprom_rw_engine #(.WRITE_CYCLES(WC)) DUT (.ref_clk(ref_clk), .rst(rst),
    .start_seen(start_seen), .stop_seen(stop_seen), .byte_valid(byte_valid),
    .byte_data(byte_data), .master_ack_valid(master_ack_valid), .master_ack(master_ack),
    .write_guard(write_guard), .slave_ack(slave_ack), .ack_valid(ack_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .prog_busy(prog_busy),
    .prog_start(prog_start), .prog_addr(prog_addr));
  two_wire_master_model m (.ref_clk(ref_clk), .slave_ack(slave_ack), .ack_valid(ack_valid),
    .tx_valid(tx_valid), .tx_data(tx_data), .start_seen(start_seen), .stop_seen(stop_seen),
    .byte_valid(byte_valid), .byte_data(byte_data), .master_ack_valid(master_ack_valid),
    .master_ack(master_ack));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2 * WC && prog_busy === 1'b1; i++) @(posedge ref_clk);
    #1;
    check(prog_busy, 1'b0);
  endtask
  task automatic wr(input logic [7:0] sa, wa, d, input int n, input logic ok);
    m.cond(1'b0);
    m.send(sa);
    check(m.got, 1'b1);
    m.send(wa);
    check(m.got, 1'b1);
    for (int k = 0; k < n; k++) begin
      m.send(d + 8'(k));
      check(m.got, ok);
    end
    m.cond(1'b1);
  endtask
  task automatic rd_at(input logic [7:0] sa, wa);
    m.cond(1'b0);
    m.send(sa);
    m.send(wa);
    m.cond(1'b0);
    m.send(sa | 8'h01);
  endtask
  task automatic test_byte_poll;
    wr(8'hAE, 8'hFF, 8'h5A, 1, 1'b1);
    check(prog_start, 1'b1);
    check(prog_addr, 11'h7F0);
    m.cond(1'b0);
    m.send(8'hA0);
    check(m.got, 1'b0);
    m.cond(1'b1);
    wait_idle();
    m.cond(1'b0);
    m.send(8'hA0);
    check(m.got, 1'b1);
    m.cond(1'b1);
    $display("byte write and polling finished");
  endtask
  task automatic test_page;
    wr(8'hA0, 8'h0E, 8'h80, 18, 1'b1);
    check(prog_addr, 11'h000);
    wait_idle();
    rd_at(8'hA0, 8'h0E);
    check(m.rx, 8'h90);
    m.next(1'b1);
    check(m.rx, 8'h91);
    m.next(1'b0);
    check(m.rx, 8'h00);
    m.cond(1'b1);
    $display("page write and random read finished");
  endtask
  task automatic test_wrap;
    rd_at(8'hAE, 8'hFF);
    check(m.rx, 8'h5A);
    m.next(1'b1);
    check(m.rx, 8'h82);
    m.next(1'b0);
    m.cond(1'b1);
    m.cond(1'b0);
    m.send(8'hA1);
    check(m.rx, 8'h83);
    m.next(1'b0);
    m.cond(1'b1);
    $display("array wrap and current read finished");
  endtask
  task automatic test_guard;
    write_guard = 1'b1;
    wr(8'hAA, 8'h10, 8'h33, 1, 1'b0);
    check({prog_start, prog_busy}, 2'b00);
    write_guard = 1'b0;
    m.cond(1'b0);
    m.send(8'h50);
    check(m.got, 1'b0);
    m.cond(1'b1);
    $display("write guard and foreign address finished");
  endtask
  initial begin
    rst = 1'b1;
    write_guard = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    test_byte_poll();
    test_page();
    test_wrap();
    test_guard();
    test_done();
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
